// >>> rtl/i2ct_pkg.sv
// constants, carriers and state record of the two-wire target controller
package i2ct_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_OWN_ADDR  = 8'h04;
  localparam logic [7:0] OFS_SPIKE_LEN = 8'h08;
  localparam logic [7:0] OFS_DATA_CMD  = 8'h0c;
  localparam logic [7:0] OFS_RAW_EVENT = 8'h10;
  localparam logic [7:0] OFS_EVT_MASK  = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_RX_LEVEL  = 8'h1c;
  localparam logic [7:0] OFS_TX_LEVEL  = 8'h20;
  localparam logic [7:0] OFS_SETUP     = 8'h24;
  // field positions
  localparam int CTL_ENABLE     = 0;
  localparam int CTL_ADDR10     = 1;
  localparam int RAW_RX_AVAIL   = 2;
  localparam int RAW_TX_EMPTY   = 4;
  localparam int RAW_RD_REQ     = 5;
  localparam int RAW_TRANSMIT_ABORT_FLAG    = 6;
  localparam int STAT_ACTIVITY  = 0;
  localparam int STAT_TX_NFULL  = 1;
  localparam int STAT_TX_EMPTY  = 2;
  localparam int STAT_RECEIVE_FIFO_NOT_EMPTY      = 3;
  // reset values
  localparam logic [3:0] CONTROL_RST  = 4'h5;
  localparam logic [9:0] OWN_ADDR_RST = 10'h055;
  localparam logic [6:0] EVT_MASK_RST = 7'h64;
  localparam logic [7:0] SETUP_RST    = 8'h01;
  // timing: widest spike to suppress, at the 20 ns ref_clk
  localparam int SPIKE_NS = 50;
  localparam int CLK_NS   = 20;
  localparam logic [7:0] SPIKE_LEN_RST = 8'((SPIKE_NS + CLK_NS - 1) / CLK_NS);
  // ten-bit address first-byte prefix
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  // fifo geometry
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_FULL = 3'h4;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2ct_pin_in_type;

  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } i2ct_pin_out_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR2, ST_ACK, ST_RX,
    ST_TX_WAIT, ST_TX, ST_TX_ACK, ST_IGNORE
  } i2ct_bus_type;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       f;
    logic [7:0] cnt;
  } i2ct_filt_type;

  typedef struct packed {
    i2ct_filt_type          scl_l;
    i2ct_filt_type          sda_l;
    logic                   scl_prev;
    logic                   sda_prev;
    i2ct_bus_type           bus;
    i2ct_bus_type           after_ack;
    logic [7:0]             shreg;
    logic [3:0]             bitcnt;
    logic                   tenbit_hit;
    logic                   mack;
    logic                   loaded;
    logic [7:0]             setup_cnt;
    logic [3:0]             ctl;
    logic [9:0]             own;
    logic [7:0]             spklen;
    logic [6:0]             mask;
    logic [1:0]             receive_threshold_level;
    logic [1:0]             tx_tl;
    logic [7:0]             setup;
    logic                   rd_req;
    logic                   transmit_abort_flag;
    logic [3:0][7:0]        tx_mem;
    logic [1:0]             tx_wr;
    logic [1:0]             tx_rd;
    logic [2:0]             tx_cnt;
    logic [3:0][7:0]        rx_mem;
    logic [1:0]             rx_wr;
    logic [1:0]             rx_rd;
    logic [2:0]             rx_cnt;
    logic                   flush_req;
    i2ct_pin_out_type       pin;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic                   irq;
  } i2ct_state_type;

  // one step of a line's spike filter, sampled through two flip-flops
  function automatic i2ct_filt_type i2ct_filter_step(
    input i2ct_filt_type f, input logic pin, input logic [7:0] lim);
    i2ct_filt_type r;
    r    = f;
    r.s1 = pin;
    r.s2 = f.s1;
    if (f.cnt == 8'h00) begin
      if (f.s2 != f.f) r.cnt = 8'h01;
    end else if (f.s2 == f.f) begin
      r.cnt = 8'h00;
    end else if (f.cnt >= lim) begin
      r.f   = f.s2;
      r.cnt = 8'h00;
    end else begin
      r.cnt = 8'(f.cnt + 8'h01);
    end
    return r;
  endfunction
endpackage

// >>> rtl/i2ct_target.sv
// two-wire bus target controller with apb register port
module i2ct_target
  import i2ct_pkg::*;
(
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic [31:0]                     prdata,
  // two-wire bus lines
  input  wire i2ct_pkg::i2ct_pin_in_type  pin_in,
  output i2ct_pkg::i2ct_pin_out_type      pin_out,
  // event output
  output logic                            event_irq
);
  import i2ct_pkg::*;

  i2ct_state_type s;
  i2ct_state_type n;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        acc;
  logic        wr_now;
  logic        rd_now;
  logic        mapped;
  logic [31:0] rd_val;
  logic [6:0]  raw_view;
  logic        tx_push;
  logic        tx_pop;
  logic        rx_push;
  logic        rx_pop;
  logic        set_rd_req;
  logic        set_abrt;
  logic        hit;
  logic [7:0]  tx_head;

  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign prdata    = s.prdata;
  assign pin_out   = s.pin;
  assign event_irq = s.irq;

  always_comb begin
    n          = s;
    set_rd_req = 1'b0;
    set_abrt   = 1'b0;
    tx_push    = 1'b0;
    tx_pop     = 1'b0;
    rx_push    = 1'b0;
    rx_pop     = 1'b0;
    hit        = 1'b0;
    mapped     = 1'b1;
    rd_val     = 32'h0000_0000;
    tx_head    = s.tx_mem[s.tx_rd];
    n.flush_req = 1'b0;

    // two-flop sync then spike filter per line
    n.scl_l    = i2ct_filter_step(s.scl_l, pin_in.scl, s.spklen);
    n.sda_l    = i2ct_filter_step(s.sda_l, pin_in.sda, s.spklen);
    n.scl_prev = s.scl_l.f;
    n.sda_prev = s.sda_l.f;
    scl_rise   = s.scl_l.f & ~s.scl_prev;
    scl_fall   = ~s.scl_l.f & s.scl_prev;
    start_c    = s.scl_l.f & s.scl_prev & s.sda_prev & ~s.sda_l.f;
    stop_c     = s.scl_l.f & s.scl_prev & ~s.sda_prev & s.sda_l.f;

    // raw view: levels for fifo thresholds, sticky for the rest
    raw_view               = 7'h00;
    raw_view[RAW_RX_AVAIL] = s.rx_cnt > {1'b0, s.receive_threshold_level};
    raw_view[RAW_TX_EMPTY] = s.tx_cnt <= {1'b0, s.tx_tl};
    raw_view[RAW_RD_REQ]   = s.rd_req;
    raw_view[RAW_TRANSMIT_ABORT_FLAG]  = s.transmit_abort_flag;

    // apb: one wait state, the write lands on the pready edge
    acc       = psel & penable;
    wr_now    = acc & s.pready & pwrite;
    rd_now    = acc & s.pready & ~pwrite;
    n.pready  = acc & ~s.pready;
    case (paddr)
      OFS_CONTROL:   rd_val[3:0] = s.ctl;
      OFS_OWN_ADDR:  rd_val[9:0] = s.own;
      OFS_SPIKE_LEN: rd_val[7:0] = s.spklen;
      OFS_DATA_CMD:  rd_val[7:0] = s.rx_mem[s.rx_rd];
      OFS_RAW_EVENT: rd_val[6:0] = raw_view;
      OFS_EVT_MASK:  rd_val[6:0] = s.mask;
      OFS_STATUS: begin
        rd_val[STAT_ACTIVITY] = s.bus != ST_IDLE;
        rd_val[STAT_TX_NFULL] = s.tx_cnt != FIFO_FULL;
        rd_val[STAT_TX_EMPTY] = s.tx_cnt == 3'h0;
        rd_val[STAT_RECEIVE_FIFO_NOT_EMPTY]     = s.rx_cnt != 3'h0;
      end
      OFS_RX_LEVEL:  rd_val[1:0] = s.receive_threshold_level;
      OFS_TX_LEVEL:  rd_val[1:0] = s.tx_tl;
      OFS_SETUP:     rd_val[7:0] = s.setup;
      default:       mapped = 1'b0;
    endcase
    if (acc & ~s.pready) begin
      n.prdata  = rd_val;
      n.pslverr = ~mapped;
    end
    if (wr_now) begin
      case (paddr)
        OFS_CONTROL:   n.ctl    = pwdata[3:0];
        OFS_OWN_ADDR:  n.own    = pwdata[9:0];
        OFS_SPIKE_LEN: n.spklen = pwdata[7:0];
        OFS_DATA_CMD:  tx_push  = s.tx_cnt != FIFO_FULL;
        OFS_EVT_MASK:  n.mask   = pwdata[6:0];
        OFS_RX_LEVEL:  n.receive_threshold_level  = pwdata[1:0];
        OFS_TX_LEVEL:  n.tx_tl  = pwdata[1:0];
        OFS_SETUP:     n.setup  = pwdata[7:0];
        default: ;
      endcase
    end
    rx_pop = rd_now & (paddr == OFS_DATA_CMD) & (s.rx_cnt != 3'h0);

    // bus state machine
    case (s.bus)
      ST_IDLE: ;
      ST_ADDR, ST_ADDR2, ST_RX: begin
        if (scl_rise && s.bitcnt != 4'h8) begin
          n.shreg  = {s.shreg[6:0], s.sda_l.f};
          n.bitcnt = 4'(s.bitcnt + 4'h1);
        end
        if (scl_fall && s.bitcnt == 4'h8) begin
          n.bitcnt = 4'h0;
          if (s.bus == ST_ADDR) begin
            if (!s.ctl[CTL_ADDR10]) begin
              hit         = s.shreg[7:1] == s.own[6:0];
              n.after_ack = s.shreg[0] ? ST_TX_WAIT : ST_RX;
            end else begin
              hit = s.shreg[7:3] == TEN_BIT_PREFIX &&
                    s.shreg[2:1] == s.own[9:8] &&
                    (!s.shreg[0] || s.tenbit_hit);
              n.after_ack = s.shreg[0] ? ST_TX_WAIT : ST_ADDR2;
            end
          end else if (s.bus == ST_ADDR2) begin
            hit          = s.shreg == s.own[7:0];
            n.tenbit_hit = hit;
            n.after_ack  = ST_RX;
          end else begin
            // a full receive fifo refuses the byte with a nack
            hit         = s.rx_cnt != FIFO_FULL;
            rx_push     = hit;
            n.after_ack = ST_RX;
          end
          n.bus        = hit ? ST_ACK : ST_IGNORE;
          n.pin.sda_oe = hit;
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          n.pin.sda_oe = 1'b0;
          n.bus        = s.after_ack;
          if (s.after_ack == ST_TX_WAIT) begin
            set_rd_req   = 1'b1;
            n.pin.scl_oe = 1'b1;
            n.loaded     = 1'b0;
            if (s.tx_cnt != 3'h0) begin
              set_abrt    = 1'b1;
              n.flush_req = 1'b1;
            end
          end
        end
      end
      ST_TX_WAIT: begin
        n.pin.scl_oe = 1'b1;
        if (!s.loaded) begin
          // hold until data is present and both flags are cleared
          if (s.tx_cnt != 3'h0 && !s.rd_req && !s.transmit_abort_flag) begin
            n.shreg      = tx_head;
            tx_pop       = 1'b1;
            n.loaded     = 1'b1;
            n.setup_cnt  = 8'h00;
            n.pin.sda_oe = ~tx_head[7];
          end
        end else if (s.setup_cnt >= s.setup) begin
          // data has been set up long enough: release the clock
          n.pin.scl_oe = 1'b0;
          n.loaded     = 1'b0;
          n.bitcnt     = 4'h0;
          n.bus        = ST_TX;
        end else begin
          n.setup_cnt = 8'(s.setup_cnt + 8'h01);
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (s.bitcnt == 4'h7) begin
            n.pin.sda_oe = 1'b0;
            n.bitcnt     = 4'h0;
            n.bus        = ST_TX_ACK;
          end else begin
            n.shreg      = {s.shreg[6:0], 1'b0};
            n.pin.sda_oe = ~s.shreg[6];
            n.bitcnt     = 4'(s.bitcnt + 4'h1);
          end
        end
      end
      ST_TX_ACK: begin
        if (scl_rise) n.mack = ~s.sda_l.f;
        if (scl_fall) begin
          if (s.mack) begin
            if (s.tx_cnt != 3'h0) begin
              n.shreg      = tx_head;
              tx_pop       = 1'b1;
              n.pin.sda_oe = ~tx_head[7];
              n.bus        = ST_TX;
            end else begin
              set_rd_req   = 1'b1;
              n.pin.scl_oe = 1'b1;
              n.loaded     = 1'b0;
              n.bus        = ST_TX_WAIT;
            end
          end else begin
            // nack ends the read; the master stops next
            n.bus = ST_IGNORE;
            if (s.tx_cnt != 3'h0) begin
              set_abrt    = 1'b1;
              n.flush_req = 1'b1;
            end
          end
        end
      end
      ST_IGNORE: ;
      default: n.bus = ST_IDLE;
    endcase

    if (start_c || stop_c || !s.ctl[CTL_ENABLE]) begin
      n.bus        = (start_c && s.ctl[CTL_ENABLE]) ? ST_ADDR : ST_IDLE;
      n.bitcnt     = 4'h0;
      n.loaded     = 1'b0;
      n.pin.sda_oe = 1'b0;
      n.pin.scl_oe = 1'b0;
      if (!start_c) n.tenbit_hit = 1'b0;
    end

    // sticky flags: a hardware set wins over a software clear
    n.rd_req  = (s.rd_req & ~(wr_now & (paddr == OFS_RAW_EVENT) &
                pwdata[RAW_RD_REQ])) | set_rd_req;
    n.transmit_abort_flag = (s.transmit_abort_flag & ~(wr_now & (paddr == OFS_RAW_EVENT) &
                pwdata[RAW_TRANSMIT_ABORT_FLAG])) | set_abrt;
    n.irq     = |(raw_view & s.mask);

    // transmit fifo: the flush is taken one cycle after the bus side asks
    if (s.flush_req) begin
      n.tx_cnt = 3'h0;
      n.tx_rd  = s.tx_wr;
    end else begin
      if (tx_push) begin
        n.tx_mem[s.tx_wr] = pwdata[7:0];
        n.tx_wr           = 2'(s.tx_wr + 2'h1);
      end
      if (tx_pop) n.tx_rd = 2'(s.tx_rd + 2'h1);
      n.tx_cnt = 3'(s.tx_cnt + {2'h0, tx_push} - {2'h0, tx_pop});
    end
    if (rx_push) begin
      n.rx_mem[s.rx_wr] = s.shreg;
      n.rx_wr           = 2'(s.rx_wr + 2'h1);
    end
    if (rx_pop) n.rx_rd = 2'(s.rx_rd + 2'h1);
    n.rx_cnt = 3'(s.rx_cnt + {2'h0, rx_push} - {2'h0, rx_pop});
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s            <= '0;
      s.scl_l.s1   <= 1'b1;
      s.scl_l.s2   <= 1'b1;
      s.scl_l.f    <= 1'b1;
      s.sda_l.s1   <= 1'b1;
      s.sda_l.s2   <= 1'b1;
      s.sda_l.f    <= 1'b1;
      s.scl_prev   <= 1'b1;
      s.sda_prev   <= 1'b1;
      s.ctl        <= CONTROL_RST;
      s.own        <= OWN_ADDR_RST;
      s.spklen     <= SPIKE_LEN_RST;
      s.mask       <= EVT_MASK_RST;
      s.setup      <= SETUP_RST;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence seq_read_addr;
    s.bus == ST_ACK && s.after_ack == ST_TX_WAIT && scl_fall &&
      s.ctl[CTL_ENABLE];
  endsequence

  sequence seq_ack_end(logic m);
    s.bus == ST_TX_ACK && scl_fall && s.mack == m && s.ctl[CTL_ENABLE];
  endsequence

  a_ack_drive:
    assert property (s.bus == ST_ACK |-> s.pin.sda_oe)
      else $error("ack slot not driven");
  a_nomatch_quiet:
    assert property (s.bus == ST_IGNORE |-> !s.pin.sda_oe)
      else $error("data line driven while ignoring");
  a_read_request:
    assert property (seq_read_addr |=> s.rd_req && s.pin.scl_oe &&
                     s.bus == ST_TX_WAIT)
      else $error("read request or stretch missing");
  a_stale_abort:
    assert property (seq_read_addr and (s.tx_cnt != 3'h0) |=>
                     s.transmit_abort_flag && s.flush_req ##1 s.tx_cnt == 3'h0)
      else $error("stale data not aborted");
  a_release_gate:
    assert property ($fell(s.pin.scl_oe) && s.bus == ST_TX |->
                     !$past(s.rd_req) && !$past(s.transmit_abort_flag))
      else $error("clock released with flags set");
  a_empty_stretch:
    assert property (seq_ack_end(1'b1) and (s.tx_cnt == 3'h0) |=>
                     s.pin.scl_oe && s.rd_req && s.bus == ST_TX_WAIT)
      else $error("empty fifo not stretched");
  a_burst_flow:
    assert property (seq_ack_end(1'b1) and (s.tx_cnt != 3'h0) |=>
                     s.bus == ST_TX && !s.pin.scl_oe && !$rose(s.rd_req))
      else $error("burst byte stalled");
  a_final_nack:
    assert property (seq_ack_end(1'b0) and (s.tx_cnt != 3'h0) |=>
                     s.transmit_abort_flag && s.flush_req ##1 s.tx_cnt == 3'h0)
      else $error("leftover bytes kept");
  a_filter_take:
    assert property ($changed(s.scl_l.f) |->
                     $past(s.scl_l.cnt) != 8'h00 &&
                     $past(s.scl_l.s2) == s.scl_l.f)
      else $error("filtered line changed without count");
  a_filter_spike:
    assert property (s.sda_l.cnt != 8'h00 && s.sda_l.s2 == s.sda_l.f |=>
                     s.sda_l.cnt == 8'h00 && $stable(s.sda_l.f))
      else $error("spike reached the filtered line");
  a_irq_mask:
    assert property (s.irq |-> $past(|(raw_view & s.mask)))
      else $error("masked event reached output");
  a_rx_store:
    assert property (rx_push && !rx_pop && s.receive_threshold_level == 2'h0 |=>
                     s.rx_cnt == 3'($past(s.rx_cnt) + 3'h1) &&
                     raw_view[RAW_RX_AVAIL])
      else $error("received byte not stored");
  a_rx_thresh:
    assert property (s.receive_threshold_level != 2'h0 && s.rx_cnt == 3'h1 |->
                     !raw_view[RAW_RX_AVAIL])
      else $error("single byte raised receive event");
  a_apb_wait:
    assert property (psel && penable && !s.pready |=> s.pready)
      else $error("apb answer late");
endmodule

// >>> verification/i2ct_bfm.sv
// behavioural two-wire bus master that drives the target's lines
module i2ct_bfm #(
  parameter int HALF = 12
) (
  // clock
  input  wire logic ref_clk,
  // wire levels seen on the bus
  input  wire logic scl,
  input  wire logic sda,
  // open-drain pulls, high pulls the line low
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // a phase of HALF cycles outlasts the target's sync and filter delay
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one bit, scl low on entry; sp adds an scl spike shorter than the filter
  task automatic bit_io(input logic b, input logic sp, output logic r);
    tick(2);
    scl_low <= ~sp;
    tick(2);
    scl_low <= 1'h1;
    tick(HALF / 2 - 4);
    sda_low <= ~b;
    tick(HALF / 2);
    scl_low <= 1'h0;
    tick(1);
    // a stretching target keeps the wire low; the bench timeout bounds it
    while (!scl) tick(1);
    tick(HALF - 1);
    r = sda;
    scl_low <= 1'h1;
  endtask
  // also serves as repeated start when scl is low on entry
  task automatic start();
    tick(HALF / 2);
    sda_low <= 1'h0;
    tick(HALF / 2);
    scl_low <= 1'h0;
    tick(HALF);
    sda_low <= 1'h1;
    tick(HALF);
    scl_low <= 1'h1;
  endtask
  task automatic stop();
    tick(HALF / 2);
    sda_low <= 1'h1;
    tick(HALF / 2);
    scl_low <= 1'h0;
    tick(HALF);
    sda_low <= 1'h0;
    tick(HALF);
  endtask
  task automatic send(input logic [7:0] b, input logic sp, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], sp, r);
    bit_io(1'h1, 1'h0, r);
    ack = ~r;
  endtask
  // ack every byte but the last, nack the last
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, 1'h0, r);
      b[i] = r;
    end
    bit_io(last, 1'h0, r);
  endtask
endmodule

// >>> verification/i2ct_target_bench.sv
// self-checking bench of the two-wire target controller
`define CHK(nm, ex, got) begin tests_run++; \
  if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module i2ct_target_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import i2ct_pkg::*;
  logic             ref_clk = 1'h0;
  logic             rst = 1'h1;
  logic             psel = 1'h0;
  logic             penable = 1'h0;
  logic             pwrite = 1'h0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic             pready, pslverr, event_irq, m_scl, m_sda, ack;
  logic [31:0]      prdata;
  i2ct_pin_in_type  pin_in;
  i2ct_pin_out_type pin_out;
  int               n_errors = 0;
  int               tests_run = 0;
  int               cyc = 0;
  integer           seed = 32'he3fc;
  logic [32:0]      exp_q[$];
  logic [32:0]      exp_w;
  logic [7:0]       d[4];
  logic [7:0]       got;
  logic [9:0]       own;
  logic [7:0]       ra[7] = '{OFS_CONTROL, OFS_OWN_ADDR, OFS_SPIKE_LEN,
                              OFS_EVT_MASK, OFS_SETUP, OFS_STATUS,
                              OFS_RAW_EVENT};
  logic [31:0]      rv[7] = '{32'h5, 32'h55, 32'h3, 32'h64, 32'h1, 32'h6,
                              32'h10};
  always #10 ref_clk = ~ref_clk;
  // pull-ups: a released line reads high
  assign pin_in = '{scl: ~(m_scl | pin_out.scl_oe),
                    sda: ~(m_sda | pin_out.sda_oe)};
  i2ct_target i2ct_target_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .pin_in(pin_in),
    .pin_out(pin_out), .event_irq(event_irq));
  i2ct_bfm i2ct_bfm_i (.ref_clk(ref_clk), .scl(pin_in.scl),
    .sda(pin_in.sda), .scl_low(m_scl), .sda_low(m_sda));
  task automatic complete_run();
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] v, input logic err = 1'h0);
    exp_q.push_back({err, w ? 32'h0 : v});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    while (!pready) @(posedge ref_clk);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic wait_oe(input logic v);
    while (pin_out.scl_oe !== v) @(posedge ref_clk);
  endtask
  // write transfer; a byte count of zero means the address must be refused
  task automatic put(input logic [7:0] a, input int k, input int n);
    i2ct_bfm_i.start();
    i2ct_bfm_i.send(a, 1'h1, ack);
    `CHK("addr ack", 1'(n > 0), ack)
    for (int i = k; i < k + n; i++) begin
      i2ct_bfm_i.send(d[i], 1'h0, ack);
      `CHK("data ack", 1'h1, ack)
    end
    i2ct_bfm_i.stop();
  endtask
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'h1) begin
      exp_w = exp_q.pop_front();
      `CHK("apb", exp_w, {pslverr, pwrite ? 32'h0 : prdata})
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    foreach (ra[i]) apb(1'h0, ra[i], rv[i]);
    apb(1'h0, 8'h28, 32'h0, 1'h1);
    // tx empty is not masked in at reset: enable it to see the output rise
    apb(1'h1, OFS_EVT_MASK, 32'h10);
    repeat (2) @(posedge ref_clk);
    `CHK("irq", 1'h1, event_irq)
    apb(1'h1, OFS_EVT_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHK("irq", 1'h0, event_irq)
    apb(1'h0, OFS_RAW_EVENT, 32'h10);
    foreach (d[i]) d[i] = 8'($random(seed));
    apb(1'h1, OFS_RX_LEVEL, 32'h1);
    put(8'haa, 0, 1);
    apb(1'h0, OFS_RAW_EVENT, 32'h10);
    apb(1'h0, OFS_STATUS, 32'he);
    put(8'h54, 0, 0);
    put(8'haa, 1, 2);
    apb(1'h0, OFS_RAW_EVENT, 32'h14);
    for (int i = 0; i < 3; i++) apb(1'h0, OFS_DATA_CMD, {24'h0, d[i]});
    apb(1'h0, OFS_STATUS, 32'h6);
    foreach (d[i]) d[i] = 8'($random(seed));
    apb(1'h1, OFS_EVT_MASK, 32'h64);
    apb(1'h1, OFS_DATA_CMD, 32'h5a);
    fork
      begin
        i2ct_bfm_i.start();
        i2ct_bfm_i.send(8'hab, 1'h0, ack);
        for (int i = 0; i < 3; i++) begin
          i2ct_bfm_i.recv(1'(i == 2), got);
          `CHK("rd byte", d[i], got)
        end
        i2ct_bfm_i.stop();
      end
      begin
        wait_oe(1'h1);
        apb(1'h0, OFS_RAW_EVENT, 32'h70);
        `CHK("irq", 1'h1, event_irq)
        apb(1'h1, OFS_DATA_CMD, {24'h0, d[0]});
        apb(1'h1, OFS_DATA_CMD, {24'h0, d[1]});
        apb(1'h1, OFS_RAW_EVENT, 32'h60);
        wait_oe(1'h0);
        wait_oe(1'h1);
        apb(1'h0, OFS_RAW_EVENT, 32'h30);
        apb(1'h1, OFS_DATA_CMD, {24'h0, d[2]});
        apb(1'h1, OFS_DATA_CMD, {24'h0, d[3]});
        apb(1'h1, OFS_RAW_EVENT, 32'h60);
      end
    join
    apb(1'h0, OFS_RAW_EVENT, 32'h50);
    own = 10'($random(seed));
    apb(1'h1, OFS_OWN_ADDR, {22'h0, own});
    apb(1'h1, OFS_CONTROL, 32'hb);
    // zero threshold so a single stored byte raises the receive event
    apb(1'h1, OFS_RX_LEVEL, 32'h0);
    fork
      begin
        i2ct_bfm_i.start();
        i2ct_bfm_i.send({TEN_BIT_PREFIX, own[9:8], 1'h0}, 1'h0, ack);
        i2ct_bfm_i.send(own[7:0], 1'h0, ack);
        `CHK("lsb ack", 1'h1, ack)
        i2ct_bfm_i.send(d[0], 1'h0, ack);
        i2ct_bfm_i.start();
        i2ct_bfm_i.send({TEN_BIT_PREFIX, own[9:8], 1'h1}, 1'h0, ack);
        `CHK("rd ack", 1'h1, ack)
        i2ct_bfm_i.recv(1'h1, got);
        `CHK("rd byte", d[1], got)
        i2ct_bfm_i.stop();
      end
      begin
        wait_oe(1'h1);
        apb(1'h1, OFS_DATA_CMD, {24'h0, d[1]});
        apb(1'h1, OFS_RAW_EVENT, 32'h60);
      end
    join
    apb(1'h0, OFS_DATA_CMD, {24'h0, d[0]});
    complete_run();
  end
endmodule
